// [src/supervisor_pkg.sv]
// Purpose: constants and carriers for the supervisor register bank
// Assumes: 100 MHz clock, eight supervised channels
// Notes:   command codes double as register addresses
package supervisor_pkg;
  localparam int NUM_CHAN = 8;
  // ==========================================================
  // command codes
  localparam logic [7:0] CMD_PAGE          = 8'h00;
  localparam logic [7:0] CMD_CLEAR_FAULTS  = 8'h03;
  localparam logic [7:0] CMD_OUT_FORMAT    = 8'h20;
  localparam logic [7:0] CMD_OT_WARN       = 8'h51;
  localparam logic [7:0] CMD_UT_WARN       = 8'h52;
  localparam logic [7:0] CMD_UT_FAULT      = 8'h53;
  localparam logic [7:0] CMD_UT_ACTION     = 8'h54;
  localparam logic [7:0] CMD_VIN_OV_FAULT  = 8'h55;
  localparam logic [7:0] CMD_VIN_OV_ACTION = 8'h56;
  localparam logic [7:0] CMD_VIN_OV_WARN   = 8'h57;
  localparam logic [7:0] CMD_VIN_UV_WARN   = 8'h58;
  localparam logic [7:0] CMD_VIN_UV_FAULT  = 8'h59;
  localparam logic [7:0] CMD_VIN_UV_ACTION = 8'h5a;
  localparam logic [7:0] CMD_GOOD_ON       = 8'h5e;
  localparam logic [7:0] CMD_GOOD_OFF      = 8'h5f;
  localparam logic [7:0] CMD_TURN_ON_DELAY     = 8'h60;
  localparam logic [7:0] CMD_TURN_ON_RISE_TIME      = 8'h61;
  localparam logic [7:0] CMD_TON_LIMIT     = 8'h62;
  localparam logic [7:0] CMD_TON_ACTION    = 8'h63;
  localparam logic [7:0] CMD_TURN_OFF_DELAY    = 8'h64;
  localparam logic [7:0] CMD_SUM_BYTE      = 8'h78;
  localparam logic [7:0] CMD_SUM_WORD      = 8'h79;
  localparam logic [7:0] CMD_VOUT_FLAGS    = 8'h7a;
  localparam logic [7:0] CMD_VIN_FLAGS     = 8'h7c;
  localparam logic [7:0] CMD_TEMP_FLAGS    = 8'h7d;
  // ==========================================================
  // reset values
  localparam logic [7:0]  RST_PAGE       = 8'h00;
  localparam logic [7:0]  OUT_FORMAT_VAL = 8'h13;
  localparam logic [15:0] RST_OT_WARN    = 16'hea30;
  localparam logic [15:0] RST_UT_WARN    = 16'h8000;
  localparam logic [15:0] RST_UT_FAULT   = 16'he580;
  localparam logic [7:0]  RST_UT_ACTION  = 8'hb8;
  localparam logic [15:0] RST_VOV_FAULT  = 16'hd3c0;
  localparam logic [7:0]  RST_VOV_ACTION = 8'h80;
  localparam logic [15:0] RST_VOV_WARN   = 16'hd380;
  localparam logic [15:0] RST_VUV_WARN   = 16'h8000;
  localparam logic [15:0] RST_VUV_FAULT  = 16'h8000;
  localparam logic [7:0]  RST_VUV_ACTION = 8'h00;
  localparam logic [15:0] RST_GOOD_ON    = 16'h1eb8;
  localparam logic [15:0] RST_GOOD_OFF   = 16'h1e14;
  localparam logic [15:0] RST_TURN_ON_DELAY  = 16'hba00;
  localparam logic [15:0] RST_TURN_ON_RISE_TIME   = 16'hd280;
  localparam logic [15:0] RST_TON_LIMIT  = 16'hd3c0;
  localparam logic [7:0]  RST_TON_ACTION = 8'hb8;
  localparam logic [15:0] RST_TURN_OFF_DELAY = 16'hba00;
  // ==========================================================
  // status bit positions
  localparam int FLAG_HI_FAULT = 7;  // over fault
  localparam int FLAG_HI_WARN  = 6;  // over warning
  localparam int FLAG_LO_WARN  = 5;  // under warning
  localparam int FLAG_LO_FAULT = 4;  // under fault
  localparam int FLAG_TON      = 2;  // turn-on timeout
  localparam int SUM_OFF       = 6;
  localparam int SUM_VIN_UV    = 3;
  localparam int SUM_TEMP      = 2;
  localparam int SUM_NONE      = 0;
  localparam int WRD_VOUT      = 15;
  localparam int WRD_INPUT     = 13;
  localparam int WRD_NOT_GOOD  = 11;
  // action bits that shut the channel down
  localparam int ACT_SHUT_HI   = 7;
  localparam int ACT_SHUT_LO   = 6;
  // ==========================================================
  // timing
  localparam int CLK_HZ         = 100_000_000;
  localparam int TICK_US        = 1000;
  localparam int TICK_CYCLES    = CLK_HZ / 1_000_000 * TICK_US;
  localparam int CLEAR_LIMIT_US = 500;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  code;
    logic [15:0] data;
  } cmd_t;
  typedef struct packed {
    logic        valid;
    logic [15:0] value;
  } meas_t;
  typedef struct packed {
    logic        valid;
    logic [2:0]  chan;
    logic [15:0] value;
  } vout_meas_t;
  typedef enum logic [4:0] {
    SEQ_OFF   = 5'b00001,
    SEQ_DELAY = 5'b00010,
    SEQ_RISE  = 5'b00100,
    SEQ_ON    = 5'b01000,
    SEQ_STOP  = 5'b10000
  } seq_state_t;
endpackage

// [src/supervisor_limits_sequencing_regs.sv]
// Purpose: limits, sequencing timers and status bank of the supervisor
// Assumes: commands arrive decoded from the serial link, one per cycle
// Notes:   linear11 words compared after scaling to a common fixed point
// Notes on behaviour
// - undertemperature fault action byte, code 54
// - input overvoltage fault limit word, code 55
// - input overvoltage fault action byte, code 56
// - input overvoltage warning limit word, code 57
// - input undervoltage warning limit word, code 58
// - input undervoltage fault limit word, code 59
// - input undervoltage fault action byte, code 5a
// - power good on at threshold, paged
// - power good off at threshold, paged
// - turn-on delay before enable goes on
// - rise time before servo starts
// - undervoltage past limit raises timeout fault
// - paged turn-on timeout fault action byte
// - turn-off delay before enable goes off
// - paged one-byte fault summary, read only
// - paged two-byte fault summary, read only
// - paged output voltage flag byte
// - input voltage flag byte, not paged
// - temperature flag byte, not paged
// - paged commands follow selected page
// - clear faults command clears set flags
// - output format byte reports exponent
`timescale 1ns/1ps
module supervisor_limits_sequencing_regs #(
  parameter int TICK_CYCLES = supervisor_pkg::TICK_CYCLES
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  // command side
  input  wire supervisor_pkg::cmd_t       cmd,
  output logic [15:0]                     rdData,
  output logic                            rdValid,
  output logic                            cmdError,
  // measurements
  input  wire supervisor_pkg::meas_t      tempMeas,
  input  wire supervisor_pkg::meas_t      vinMeas,
  input  wire supervisor_pkg::vout_meas_t voutMeas,
  // supply side
  input  wire logic [7:0]                 onRequest,
  output logic [7:0]                      channelEnableOut,
  output logic [7:0]                      servoStart,
  output logic [7:0]                      powerGood,
  output logic [7:0]                      turnOnTimeoutFault
);
  localparam int NC = supervisor_pkg::NUM_CHAN;

  // linear11 to value scaled by 2^16; exponent+16 is {~e[4],e[3:0]}
  function automatic logic signed [47:0] l11Fixed(input logic [15:0] w);
    logic signed [47:0] m;
    logic [4:0]         sh;
    m  = 48'(signed'(w[10:0]));
    sh = {~w[15], w[14:11]};
    return m <<< sh;
  endfunction

  // whole milliseconds, saturating, negative as zero
  function automatic logic [15:0] l11Ms(input logic [15:0] w);
    logic signed [47:0] f;
    f = l11Fixed(w);
    if (f < 0) return 16'h0000;
    if (f[47:32] != 16'h0000) return 16'hffff;
    return f[31:16];
  endfunction

  // strictly past target, so a wait is never cut short by tick phase
  function automatic logic waitDone(input logic [15:0] el, tgt);
    return (tgt == 16'h0000) || (el > tgt) || (&el);
  endfunction

  // ==========================================================
  // input synchronisers and millisecond tick
  logic [7:0]  onMeta_q, onSync_q;
  logic [31:0] tickCnt_q;
  logic        msTick_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      onMeta_q <= 8'h00;
      onSync_q <= 8'h00;
    end else begin
      onMeta_q <= onRequest;
      onSync_q <= onMeta_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tickCnt_q <= 32'h0;
      msTick_q  <= 1'b0;
    end else begin
      msTick_q  <= (tickCnt_q == 32'(TICK_CYCLES - 1));
      tickCnt_q <= (tickCnt_q == 32'(TICK_CYCLES - 1)) ? 32'h0
                                                       : tickCnt_q + 32'h1;
    end
  end

  // ==========================================================
  // command decode
  wire wrEn   = cmd.valid & cmd.write;
  wire rdEn   = cmd.valid & ~cmd.write;
  wire clrCmd = cmd.valid & (cmd.code == supervisor_pkg::CMD_CLEAR_FAULTS);
  wire [7:0]  wByte = cmd.data[7:0];

  // ==========================================================
  // non-paged registers
  logic [2:0]  page_q;
  logic [15:0] otWarn_q, utWarn_q, utFault_q;
  logic [7:0]  utAction_q, vovAction_q, vuvAction_q;
  logic [15:0] vovFault_q, vovWarn_q, vuvWarn_q, vuvFault_q;
  logic [7:0]  pageRaw_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pageRaw_q   <= supervisor_pkg::RST_PAGE;
      otWarn_q    <= supervisor_pkg::RST_OT_WARN;
      utWarn_q    <= supervisor_pkg::RST_UT_WARN;
      utFault_q   <= supervisor_pkg::RST_UT_FAULT;
      utAction_q  <= supervisor_pkg::RST_UT_ACTION;
      vovFault_q  <= supervisor_pkg::RST_VOV_FAULT;
      vovAction_q <= supervisor_pkg::RST_VOV_ACTION;
      vovWarn_q   <= supervisor_pkg::RST_VOV_WARN;
      vuvWarn_q   <= supervisor_pkg::RST_VUV_WARN;
      vuvFault_q  <= supervisor_pkg::RST_VUV_FAULT;
      vuvAction_q <= supervisor_pkg::RST_VUV_ACTION;
    end else if (wrEn) begin
      case (cmd.code)
        supervisor_pkg::CMD_PAGE:          pageRaw_q   <= wByte;
        supervisor_pkg::CMD_OT_WARN:       otWarn_q    <= cmd.data;
        supervisor_pkg::CMD_UT_WARN:       utWarn_q    <= cmd.data;
        supervisor_pkg::CMD_UT_FAULT:      utFault_q   <= cmd.data;
        supervisor_pkg::CMD_UT_ACTION:     utAction_q  <= wByte;
        supervisor_pkg::CMD_VIN_OV_FAULT:  vovFault_q  <= cmd.data;
        supervisor_pkg::CMD_VIN_OV_ACTION: vovAction_q <= wByte;
        supervisor_pkg::CMD_VIN_OV_WARN:   vovWarn_q   <= cmd.data;
        supervisor_pkg::CMD_VIN_UV_WARN:   vuvWarn_q   <= cmd.data;
        supervisor_pkg::CMD_VIN_UV_FAULT:  vuvFault_q  <= cmd.data;
        supervisor_pkg::CMD_VIN_UV_ACTION: vuvAction_q <= wByte;
        default: ;
      endcase
    end
  end
  assign page_q = pageRaw_q[2:0];

  // ==========================================================
  // temperature and input limit checks
  wire signed [47:0] tempFx = l11Fixed(tempMeas.value);
  wire signed [47:0] vinFx  = l11Fixed(vinMeas.value);
  wire tOverWarn  = tempFx > l11Fixed(otWarn_q);
  wire tUnderWarn = tempFx < l11Fixed(utWarn_q);
  wire tUnderFlt  = tempFx < l11Fixed(utFault_q);
  wire vOverFlt   = vinFx > l11Fixed(vovFault_q);
  wire vOverWarn  = vinFx > l11Fixed(vovWarn_q);
  wire vUnderWarn = vinFx < l11Fixed(vuvWarn_q);
  wire vUnderFlt  = vinFx < l11Fixed(vuvFault_q);
  wire [7:0] tempSet = {1'b0, tOverWarn, tUnderWarn, tUnderFlt, 4'h0};
  wire [7:0] vinSet  = {vOverFlt, vOverWarn, vUnderWarn, vUnderFlt, 4'h0};

  logic [7:0] tempFlags_q, vinFlags_q;

  // set wins over clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tempFlags_q <= 8'h00;
      vinFlags_q  <= 8'h00;
    end else begin
      tempFlags_q <= (clrCmd ? 8'h00 : tempFlags_q)
                     | (tempMeas.valid ? tempSet : 8'h00);
      vinFlags_q  <= (clrCmd ? 8'h00 : vinFlags_q)
                     | (vinMeas.valid ? vinSet : 8'h00);
    end
  end

  // fault actions that shut every channel down
  wire utShut  = tempFlags_q[supervisor_pkg::FLAG_LO_FAULT]
                 & (utAction_q[supervisor_pkg::ACT_SHUT_HI]
                    | utAction_q[supervisor_pkg::ACT_SHUT_LO]);
  wire vovShut = vinFlags_q[supervisor_pkg::FLAG_HI_FAULT]
                 & (vovAction_q[supervisor_pkg::ACT_SHUT_HI]
                    | vovAction_q[supervisor_pkg::ACT_SHUT_LO]);
  wire vuvShut = vinFlags_q[supervisor_pkg::FLAG_LO_FAULT]
                 & (vuvAction_q[supervisor_pkg::ACT_SHUT_HI]
                    | vuvAction_q[supervisor_pkg::ACT_SHUT_LO]);
  wire allShut = utShut | vovShut | vuvShut;

  // ==========================================================
  // per-channel registers, power good and sequencer
  logic [15:0] goodOn_q   [NC];
  logic [15:0] goodOff_q  [NC];
  logic [15:0] tonDelay_q [NC];
  logic [15:0] tonRise_q  [NC];
  logic [15:0] tonLimit_q [NC];
  logic [7:0]  tonAction_q[NC];
  logic [15:0] toffDelay_q[NC];
  logic [7:0]  voutFlags_q[NC];

  genvar g;
  generate
    for (g = 0; g < NC; g++) begin : gChan
      wire sel = (page_q == 3'(g));
      supervisor_pkg::seq_state_t state_q, state_d;
      logic [15:0] elapsed_q, onTime_q;
      logic        enable_q, servo_q, good_q, tonFlt_q;

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          goodOn_q[g]    <= supervisor_pkg::RST_GOOD_ON;
          goodOff_q[g]   <= supervisor_pkg::RST_GOOD_OFF;
          tonDelay_q[g]  <= supervisor_pkg::RST_TURN_ON_DELAY;
          tonRise_q[g]   <= supervisor_pkg::RST_TURN_ON_RISE_TIME;
          tonLimit_q[g]  <= supervisor_pkg::RST_TON_LIMIT;
          tonAction_q[g] <= supervisor_pkg::RST_TON_ACTION;
          toffDelay_q[g] <= supervisor_pkg::RST_TURN_OFF_DELAY;
        end else if (wrEn && sel) begin
          case (cmd.code)
            supervisor_pkg::CMD_GOOD_ON:    goodOn_q[g]    <= cmd.data;
            supervisor_pkg::CMD_GOOD_OFF:   goodOff_q[g]   <= cmd.data;
            supervisor_pkg::CMD_TURN_ON_DELAY:  tonDelay_q[g]  <= cmd.data;
            supervisor_pkg::CMD_TURN_ON_RISE_TIME:   tonRise_q[g]   <= cmd.data;
            supervisor_pkg::CMD_TON_LIMIT:  tonLimit_q[g]  <= cmd.data;
            supervisor_pkg::CMD_TON_ACTION: tonAction_q[g] <= wByte;
            supervisor_pkg::CMD_TURN_OFF_DELAY: toffDelay_q[g] <= cmd.data;
            default: ;
          endcase
        end
      end

      // power good hysteresis on linear16 readings
      wire mine = voutMeas.valid && (voutMeas.chan == 3'(g));
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          good_q <= 1'b0;
        end else if (mine) begin
          if (voutMeas.value >= goodOn_q[g]) begin
            good_q <= 1'b1;
          end else if (voutMeas.value <= goodOff_q[g]) begin
            good_q <= 1'b0;
          end
        end
      end

      wire tonShut = tonFlt_q & (tonAction_q[g][supervisor_pkg::ACT_SHUT_HI]
                     | tonAction_q[g][supervisor_pkg::ACT_SHUT_LO]);
      wire wantOn  = onSync_q[g] & ~allShut & ~tonShut;
      wire [15:0] tgtOn   = l11Ms(tonDelay_q[g]);
      wire [15:0] tgtRise = l11Ms(tonRise_q[g]);
      wire [15:0] tgtOff  = l11Ms(toffDelay_q[g]);
      wire [15:0] tgtMax  = l11Ms(tonLimit_q[g]);
      wire hardOff = allShut | tonShut;

      always_comb begin
        state_d = state_q;
        case (state_q)
          supervisor_pkg::SEQ_OFF:
            if (wantOn) state_d = supervisor_pkg::SEQ_DELAY;
          supervisor_pkg::SEQ_DELAY:
            if (!wantOn) state_d = supervisor_pkg::SEQ_OFF;
            else if (waitDone(elapsed_q, tgtOn))
              state_d = supervisor_pkg::SEQ_RISE;
          supervisor_pkg::SEQ_RISE:
            if (hardOff) state_d = supervisor_pkg::SEQ_OFF;
            else if (!wantOn) state_d = supervisor_pkg::SEQ_STOP;
            else if (waitDone(elapsed_q, tgtRise))
              state_d = supervisor_pkg::SEQ_ON;
          supervisor_pkg::SEQ_ON:
            if (hardOff) state_d = supervisor_pkg::SEQ_OFF;
            else if (!wantOn) state_d = supervisor_pkg::SEQ_STOP;
          supervisor_pkg::SEQ_STOP:
            if (hardOff || waitDone(elapsed_q, tgtOff))
              state_d = supervisor_pkg::SEQ_OFF;
            else if (wantOn) state_d = supervisor_pkg::SEQ_ON;
          default: state_d = supervisor_pkg::SEQ_OFF;
        endcase
      end

      wire onLike = (state_d == supervisor_pkg::SEQ_RISE)
                    | (state_d == supervisor_pkg::SEQ_ON)
                    | (state_d == supervisor_pkg::SEQ_STOP);

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          state_q   <= supervisor_pkg::SEQ_OFF;
          elapsed_q <= 16'h0;
          enable_q  <= 1'b0;
          servo_q   <= 1'b0;
        end else begin
          state_q   <= state_d;
          if (state_d != state_q) elapsed_q <= 16'h0;
          else if (msTick_q && elapsed_q != 16'hffff)
            elapsed_q <= elapsed_q + 16'h1;
          enable_q  <= onLike;
          servo_q   <= (state_d == supervisor_pkg::SEQ_ON);
        end
      end

      // undervoltage tolerated only up to the turn-on limit
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          onTime_q <= 16'h0;
          tonFlt_q <= 1'b0;
        end else begin
          if (!enable_q || good_q) onTime_q <= 16'h0;
          else if (msTick_q && onTime_q != 16'hffff)
            onTime_q <= onTime_q + 16'h1;
          tonFlt_q <= (clrCmd ? 1'b0 : tonFlt_q)
                      | (enable_q & ~good_q & (onTime_q > tgtMax));
        end
      end

      assign voutFlags_q[g] = {5'h00, tonFlt_q, 2'b00};
      assign channelEnableOut[g]   = enable_q;
      assign servoStart[g]         = servo_q;
      assign powerGood[g]          = good_q;
      assign turnOnTimeoutFault[g] = tonFlt_q;
    end
  endgenerate

  // ==========================================================
  // read path
  wire [7:0] selVout  = voutFlags_q[page_q];
  wire       selOff   = ~channelEnableOut[page_q];
  wire       tempAny  = |tempFlags_q;
  wire [7:0] sumByte;
  assign sumByte[7]   = 1'b0;
  assign sumByte[supervisor_pkg::SUM_OFF] = selOff;
  assign sumByte[5:4] = 2'b00;
  assign sumByte[supervisor_pkg::SUM_VIN_UV] =
    vinFlags_q[supervisor_pkg::FLAG_LO_FAULT];
  assign sumByte[supervisor_pkg::SUM_TEMP] = tempAny;
  assign sumByte[1]   = 1'b0;
  assign sumByte[supervisor_pkg::SUM_NONE] =
    ~(|{sumByte[7:1], |selVout, |vinFlags_q});
  wire [7:0] sumHigh = {|selVout, 1'b0, |vinFlags_q, 1'b0,
                        ~powerGood[page_q], 3'b000};

  logic [15:0] rdMux;
  logic        rdHit;
  always_comb begin
    rdHit = 1'b1;
    case (cmd.code)
      supervisor_pkg::CMD_PAGE:          rdMux = {8'h00, pageRaw_q};
      supervisor_pkg::CMD_OUT_FORMAT:
        rdMux = {8'h00, supervisor_pkg::OUT_FORMAT_VAL};
      supervisor_pkg::CMD_OT_WARN:       rdMux = otWarn_q;
      supervisor_pkg::CMD_UT_WARN:       rdMux = utWarn_q;
      supervisor_pkg::CMD_UT_FAULT:      rdMux = utFault_q;
      supervisor_pkg::CMD_UT_ACTION:     rdMux = {8'h00, utAction_q};
      supervisor_pkg::CMD_VIN_OV_FAULT:  rdMux = vovFault_q;
      supervisor_pkg::CMD_VIN_OV_ACTION: rdMux = {8'h00, vovAction_q};
      supervisor_pkg::CMD_VIN_OV_WARN:   rdMux = vovWarn_q;
      supervisor_pkg::CMD_VIN_UV_WARN:   rdMux = vuvWarn_q;
      supervisor_pkg::CMD_VIN_UV_FAULT:  rdMux = vuvFault_q;
      supervisor_pkg::CMD_VIN_UV_ACTION: rdMux = {8'h00, vuvAction_q};
      supervisor_pkg::CMD_GOOD_ON:       rdMux = goodOn_q[page_q];
      supervisor_pkg::CMD_GOOD_OFF:      rdMux = goodOff_q[page_q];
      supervisor_pkg::CMD_TURN_ON_DELAY:     rdMux = tonDelay_q[page_q];
      supervisor_pkg::CMD_TURN_ON_RISE_TIME:      rdMux = tonRise_q[page_q];
      supervisor_pkg::CMD_TON_LIMIT:     rdMux = tonLimit_q[page_q];
      supervisor_pkg::CMD_TON_ACTION:    rdMux = {8'h00, tonAction_q[page_q]};
      supervisor_pkg::CMD_TURN_OFF_DELAY:    rdMux = toffDelay_q[page_q];
      supervisor_pkg::CMD_SUM_BYTE:      rdMux = {8'h00, sumByte};
      supervisor_pkg::CMD_SUM_WORD:      rdMux = {sumHigh, sumByte};
      supervisor_pkg::CMD_VOUT_FLAGS:    rdMux = {8'h00, selVout};
      supervisor_pkg::CMD_VIN_FLAGS:     rdMux = {8'h00, vinFlags_q};
      supervisor_pkg::CMD_TEMP_FLAGS:    rdMux = {8'h00, tempFlags_q};
      default: begin
        rdMux = 16'h0000;
        rdHit = 1'b0;
      end
    endcase
  end

  wire roCode = (cmd.code == supervisor_pkg::CMD_OUT_FORMAT)
                | (cmd.code >= supervisor_pkg::CMD_SUM_BYTE);
  wire wrBad  = wrEn & ~clrCmd & (~rdHit | roCode);
  wire rdBad  = rdEn & ~clrCmd & ~rdHit;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData   <= 16'h0000;
      rdValid  <= 1'b0;
      cmdError <= 1'b0;
    end else begin
      rdValid  <= rdEn & ~clrCmd;
      cmdError <= wrBad | rdBad;
      if (rdEn && !clrCmd) rdData <= rdMux;
    end
  end
endmodule

// [bench/supervisor_props.sv]
// Purpose: port checker for the supervisor bank
// Assumes: one clock, async active-high reset
// Notes:   good thresholds stay at reset values on page 0
`timescale 1ns/1ps
module supervisor_props #(
  parameter int TICK_CYCLES = 10
) (
  // clock and reset
  input wire logic                       clk,
  input wire logic                       rst,
  // command side
  input wire supervisor_pkg::cmd_t       cmd,
  input wire logic                       rdValid,
  input wire logic                       cmdError,
  // supply side
  input wire supervisor_pkg::vout_meas_t voutMeas,
  input wire logic [7:0]                 onRequest,
  input wire logic [7:0]                 channelEnableOut,
  input wire logic [7:0]                 servoStart,
  input wire logic [7:0]                 powerGood
);
  // ======
  // assertions
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic isRd = cmd.valid && !cmd.write && cmd.code != 8'h03;
  wire logic v0 = voutMeas.valid && voutMeas.chan == 3'd0;
  a_read_answered: assert property (isRd |=> rdValid)
    else $error("read not answered");
  a_write_silent: assert property (cmd.valid && cmd.write |=> !rdValid)
    else $error("write gave read data");
  a_ro_refused: assert property (cmd.valid && cmd.write &&
    cmd.code inside {8'h78, 8'h79, 8'h7a, 8'h7c, 8'h7d} |=> cmdError)
    else $error("read-only write not refused");
  a_clear_quiet: assert property (cmd.valid && cmd.code == 8'h03
    |=> !rdValid && !cmdError) else $error("clear gave answer");
  a_good_on: assert property (v0 && voutMeas.value >= 16'h1eb8
    |=> powerGood[0]) else $error("good not asserted");
  a_good_off: assert property (v0 && voutMeas.value <= 16'h1e14
    |=> !powerGood[0]) else $error("good not removed");
  a_enable_cause: assert property ($rose(channelEnableOut[0])
    |-> $past(onRequest[0], 3)) else $error("enable without request");
  a_servo_order: assert property ($rose(servoStart[0])
    |-> $past(channelEnableOut[0])) else $error("servo before enable");
  c_enable: cover property ($rose(channelEnableOut[0]));
  c_good: cover property ($rose(powerGood[0]));
  c_error: cover property (cmdError);
endmodule

// [bench/supply_model.sv]
// Purpose: supervised converters ramping on their enables
// Assumes: one output sample per cycle, channels in turn
// Notes:   a slow channel parks below the good window
`timescale 1ns/1ps
module supply_model (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // enables and stall control
  input  wire logic [7:0]            enable,
  input  wire logic [7:0]            slow,
  // samples
  output supervisor_pkg::vout_meas_t voutMeas
);
  // ======
  // ramp per channel
  logic [2:0]  chQ;
  logic [15:0] voltQ [8];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chQ <= 3'h0;
      for (int i = 0; i < 8; i++) voltQ[i] <= 16'h0000;
    end else begin
      chQ <= chQ + 3'h1;
      if (!enable[chQ]) voltQ[chQ] <= 16'h0000;
      else if (slow[chQ]) voltQ[chQ] <= 16'h0800;
      else if (voltQ[chQ] < 16'h2000) voltQ[chQ] <= voltQ[chQ] + 16'h0400;
    end
  end
  // linear16 volts, exponent minus thirteen
  assign voutMeas = '{!rst, chQ, voltQ[chQ]};
endmodule

// [bench/supervisor_limits_sequencing_regs_tb.sv]
// Purpose: self-checking bench for the supervisor bank
// Assumes: TICK_CYCLES of 10, one ms is ten cycles
// Notes:   expected registers kept per page
`timescale 1ns/1ps
module supervisor_limits_sequencing_regs_tb;
  localparam int TICK = 10;
  logic clk = 0, rst = 1;
  supervisor_pkg::cmd_t       cmd = '0;
  supervisor_pkg::meas_t      tempMeas = '0, vinMeas = '0;
  supervisor_pkg::vout_meas_t voutMeas;
  logic [15:0] rdData, d, m [8][256];
  logic        rdValid, cmdError;
  logic [7:0]  onRequest = '0, slow = '0, en, pg, tof, sv;
  logic [2:0]  pageSel = '0;
  int          failures = 0, testsRun = 0, seed = 90, n;
  logic [15:0] rv [17] = '{16'hea30, 16'h8000, 16'he580, 16'h00b8,
    16'hd3c0, 16'h0080, 16'hd380, 16'h8000, 16'h8000, 16'h0000, 16'h1eb8,
    16'h1e14, 16'hba00, 16'hd280, 16'hd3c0, 16'h00b8, 16'hba00};
  initial forever #5 clk = ~clk;
  supervisor_limits_sequencing_regs #(.TICK_CYCLES(TICK)) dut_u (
    .clk(clk), .rst(rst), .cmd(cmd), .rdData(rdData), .rdValid(rdValid),
    .cmdError(cmdError), .tempMeas(tempMeas), .vinMeas(vinMeas),
    .voutMeas(voutMeas), .onRequest(onRequest), .channelEnableOut(en),
    .servoStart(sv), .powerGood(pg), .turnOnTimeoutFault(tof));
  supply_model model_u (.clk(clk), .rst(rst), .enable(en), .slow(slow),
    .voutMeas(voutMeas));
  task report_and_stop;
    if (failures == 0 && testsRun > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] seen, exp);
    testsRun++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task op(input logic w, input logic [7:0] c, input logic [15:0] v);
    @(negedge clk);
    cmd = '{1'b1, w, c, v};
    @(negedge clk);
    cmd.valid = 1'b0;
  endtask
  task wr(input logic [7:0] c, input logic [15:0] v);
    op(1'b1, c, v);
    if (c == 8'h00) pageSel = v[2:0];
    for (int p = 0; p < 8; p++)
      if (!(c inside {[8'h5e:8'h64]}) || p == pageSel)
        m[p][c] = c inside {8'h54, 8'h56, 8'h5a, 8'h63} ? {8'h00, v[7:0]} : v;
  endtask
  task rd(input logic [7:0] c, input logic [15:0] e);
    op(1'b0, c, 16'h0000);
    chk("rdValid", rdValid, 16'h0001);
    chk("rdData", rdData, e);
  endtask
  initial begin
    for (int p = 0; p < 8; p++) begin
      for (int c = 0; c < 256; c++) m[p][c] = 16'h0000;
      for (int c = 'h51, k = 0; c <= 'h64; c++)
        if (!(c inside {['h5b:'h5d]})) m[p][c] = rv[k++];
    end
    repeat (5) @(negedge clk);
    rst = 0;
    for (int c = 'h51; c <= 'h64; c++)
      if (!(c inside {['h5b:'h5d]})) rd(8'(c), m[0][c]);
    rd(8'h20, 16'h0013);
    d = 16'($random(seed));
    wr(8'h57, d);
    rd(8'h57, m[0][8'h57]);
    wr(8'h54, d);
    rd(8'h54, m[0][8'h54]);
    wr(8'h00, 16'h0003);
    wr(8'h60, d);
    rd(8'h60, m[3][8'h60]);
    rd(8'h57, m[3][8'h57]);
    wr(8'h00, 16'h0000);
    rd(8'h60, m[0][8'h60]);
    rd(8'hff, 16'h0000);
    chk("unmapped", cmdError, 16'h0001);
    op(1'b1, 8'h78, d);
    chk("roWrite", cmdError, 16'h0001);
    onRequest = 8'h03;
    slow = 8'h02;
    n = 0;
    while (en[0] !== 1'b1 && n < 100) begin @(negedge clk); n++; end
    chk("onDelay", n >= TICK && n <= 3 * TICK, 16'h0001);
    while (pg[0] !== 1'b1 && n < 400) begin @(negedge clk); n++; end
    chk("good", pg[0], 16'h0001);
    while (tof[1] !== 1'b1 && n < 900) begin @(negedge clk); n++; end
    chk("tonFault", tof[1], 16'h0001);
    wr(8'h00, 16'h0001);
    op(1'b0, 8'h7a, 16'h0000);
    chk("voutFlags", rdData[2], 16'h0001);
    chk("shutOff", en[1], 16'h0000);
    chk("servo", sv[0], 16'h0001);
    onRequest = 8'h00;
    n = 0;
    while (en[0] !== 1'b0 && n < 100) begin @(negedge clk); n++; end
    chk("offDelay", n >= TICK && n <= 3 * TICK, 16'h0001);
    wr(8'h57, 16'hd380);
    vinMeas = '{1'b1, 16'hd3c1 + 16'($random(seed) & 31)};
    tempMeas = '{1'b1, 16'h07ce};
    @(negedge clk);
    vinMeas.valid = 1'b0;
    tempMeas.valid = 1'b0;
    rd(8'h7c, 16'h00c0);
    rd(8'h7d, 16'h0030);
    op(1'b1, 8'h03, 16'h0000);
    rd(8'h7c, 16'h0000);
    rd(8'h78, 16'h0040);
    rd(8'h79, 16'h0840);
    report_and_stop;
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    report_and_stop;
  end
endmodule
bind supervisor_limits_sequencing_regs supervisor_props #(
  .TICK_CYCLES(TICK_CYCLES)) props_u (.clk(clk), .rst(rst), .cmd(cmd),
  .rdValid(rdValid), .cmdError(cmdError), .voutMeas(voutMeas),
  .onRequest(onRequest), .channelEnableOut(channelEnableOut),
  .servoStart(servoStart), .powerGood(powerGood));
